// [common/irq_pkg.sv]
// package: register map, reset values and event types for the irq controller
package irq_pkg;
    // register byte addresses on apb
    localparam logic [7:0] IRQ_MISC_ADDR = 8'h0C;
    localparam logic [7:0] IRQ_CPU_ADDR = 8'h10;
    localparam logic [7:0] IRQ_TIMER_ADDR = 8'h14;
    localparam logic [7:0] IRQ_SERIAL_ADDR = 8'h18;
    localparam logic [7:0] IRQ_CMD_ADDR = 8'h1C;
    localparam logic [7:0] IRQ_VEC_ADDR = 8'h20;
    // misc register fields
    localparam int POR_BIT = 7;
    localparam int RISE_BIT = 6;
    localparam int FALL_BIT = 5;
    localparam int EXT_EN_BIT = 4;
    localparam int FLAG_A_BIT = 3;
    localparam int FLAG_B_BIT = 2;
    localparam int SLOW_BIT = 1;
    localparam int COP_BIT = 0;
    localparam logic [7:0] MISC_RST = 8'h10;
    localparam logic [7:0] MISC_POR_VAL = 8'h90;
    // cpu side reset values
    localparam logic [15:0] TIMER_RST = 16'hFFFC;
    localparam logic [15:0] SP_RST = 16'h00FF;
    // vectors, high byte address; low byte at next address
    localparam logic [15:0] VEC_RESET = 16'h1FFE;
    localparam logic [15:0] VEC_TRAP = 16'h1FFC;
    localparam logic [15:0] VEC_EXT = 16'h1FFA;
    localparam logic [15:0] VEC_CAPT = 16'h1FF8;
    localparam logic [15:0] VEC_CMP = 16'h1FF6;
    localparam logic [15:0] VEC_WRAP = 16'h1FF4;
    localparam logic [15:0] VEC_SER = 16'h1FF2;
    // oscillator hold
    localparam int OSC_HOLD_CYC = 4064;
    // command register bits (software / core events)
    localparam int CMD_WAIT = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_TRAP = 2;
    localparam int CMD_RTI = 3;
    localparam int CMD_BOUND = 4;
    localparam int CMD_EXTRST = 5;

    typedef enum logic [2:0] {
        IRQ_SRC_NONE = 3'h0,
        IRQ_SRC_TRAP = 3'h1,
        IRQ_SRC_EXT = 3'h2,
        IRQ_SRC_CAPT = 3'h3,
        IRQ_SRC_CMP = 3'h4,
        IRQ_SRC_WRAP = 3'h5,
        IRQ_SRC_SER = 3'h6
    } irq_src_e;

    // per-function effects driven out to peripherals
    typedef struct packed {
        logic timer_reset;
        logic ddr_clear;
        logic serial_reset;
        logic clk_clear;
        logic adc_disable;
        logic eeprom_reset;
        logic cop_count_reset;
        logic fetch_restart;
    } irq_fx_s;
endpackage : irq_pkg

// [rtl/irq_ctrl.sv]
// irq_ctrl: interrupt arbitration and reset/wait/stop effects controller
// Function
// R1 - reset zeroes prescaler, loads FFFC, clears enables
// R2 - reset clears ddr, sp 00FF, vector, sets mask
// R3 - wait and stop clear mask bit
// R4 - only power-on sets power-up flag
// R5 - resets clear enables but set external enable
// R6 - resets disable serial, set tx flags
// R7 - power-on and stop hold oscillator 4064
// R8 - resets and stop clear adc, slow, cop
// R9 - all four events reset watchdog counter
// R10 - take: stack, set mask; return restores mask
// R11 - pending until instruction boundary, masked, enabled
// R12 - fixed priority reset trap ext timer serial
// R13 - fixed vector addresses per source
// R14 - trap ignores mask, after earlier pending
// R15 - external needs mask clear, enable, sensitivity
// R16 - select bits choose edge or level mode
// R17 - select and enable writable only masked
// R18 - resets clear selects, set enable
// R19 - changing sensitivity clears pending external
// R20 - edge latched even while enable clear
// R21 - latch cleared at service, level unlatched; code also latches a falling edge in level mode
// R22 - misc register layout, power-up bits 4,7
// R23 - power-up flag clear-only by software
// R24 - level mode tracks pin, no latch; code also latches a falling edge in level mode
`timescale 1ns/100ps
module irq_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_pulse,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic irq_pin_n,
    input wire logic capture_req,
    input wire logic compare_req,
    input wire logic wrap_req,
    input wire logic serial_req,
    output irq_pkg::irq_fx_s fx_ff,
    output logic osc_enable,
    output logic [15:0] vector_ff,
    output logic take_ff,
    output logic mask_ff
);
    import irq_pkg::*;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic wr, rd_hit;
    logic [7:0] misc_ff, nxt_misc, prescale_ff;
    logic [3:0] timer_en_ff, ser_en_ff, pend_snap_ff;
    logic [15:0] timer_cnt_ff, sp_ff;
    logic ser_on_ff, tx_empty_ff, tx_done_ff;
    logic [12:0] osc_cnt_ff;
    logic [2:0] pin_sync_ff;
    logic ext_latch_ff, trap_pend_ff, mask_stack_ff;
    irq_src_e src_ff;
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    always_comb begin
        rd_hit = 1'b1;
        prdata = 32'h0000_0000;
        case (paddr)
            IRQ_MISC_ADDR: prdata = {24'h00_0000, misc_ff};
            IRQ_CPU_ADDR: prdata = {15'h0000, mask_ff, sp_ff};
            IRQ_TIMER_ADDR: prdata = {4'h0, timer_en_ff, prescale_ff,
                                      timer_cnt_ff};
            IRQ_SERIAL_ADDR: prdata = {24'h00_0000, ser_on_ff, tx_empty_ff,
                                       tx_done_ff, 1'b0, ser_en_ff};
            IRQ_VEC_ADDR: prdata = {13'h0000, src_ff, vector_ff};
            IRQ_CMD_ADDR: prdata = 32'h0000_0000;
            default: rd_hit = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~rd_hit;
    logic cmd_wait, cmd_stop, cmd_trap, cmd_rti, cmd_bound, cmd_ext, cmd_wr;
    assign cmd_wr = wr & (paddr == IRQ_CMD_ADDR);
    assign cmd_wait = cmd_wr & pwdata[CMD_WAIT];
    assign cmd_stop = cmd_wr & pwdata[CMD_STOP];
    assign cmd_trap = cmd_wr & pwdata[CMD_TRAP];
    assign cmd_rti = cmd_wr & pwdata[CMD_RTI];
    assign cmd_bound = cmd_wr & pwdata[CMD_BOUND];
    assign cmd_ext = cmd_wr & pwdata[CMD_EXTRST];

    // por arrives asynchronously: synchronise before use
    logic por_s1_ff, por_s2_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_s1_ff <= 1'b0;
            por_s2_ff <= 1'b0;
        end else begin
            por_s1_ff <= por_pulse;
            por_s2_ff <= por_s1_ff;
        end
    end
    logic any_rst, por_evt;
    assign por_evt = por_s2_ff;
    assign any_rst = por_evt | cmd_ext;

    // ------------------------------------------------------------
    // misc register
    // ------------------------------------------------------------
    logic sel_change, misc_wr;
    assign misc_wr = wr & (paddr == IRQ_MISC_ADDR);
    always_comb begin
        nxt_misc = misc_ff;
        if (misc_wr) begin
            if (!pwdata[POR_BIT])
                nxt_misc[POR_BIT] = 1'b0; // [R23]
            if (mask_ff) begin
                nxt_misc[RISE_BIT] = pwdata[RISE_BIT]; // [R17]
                nxt_misc[FALL_BIT] = pwdata[FALL_BIT];
                nxt_misc[EXT_EN_BIT] = pwdata[EXT_EN_BIT];
            end
            nxt_misc[FLAG_A_BIT] = pwdata[FLAG_A_BIT];
            nxt_misc[FLAG_B_BIT] = pwdata[FLAG_B_BIT];
            nxt_misc[SLOW_BIT] = pwdata[SLOW_BIT];
            // cop enable cannot be cleared by software
            if (pwdata[COP_BIT])
                nxt_misc[COP_BIT] = 1'b1;
        end
        if (cmd_stop) begin
            nxt_misc[SLOW_BIT] = 1'b0; // [R8]
            nxt_misc[COP_BIT] = 1'b0;
        end
        if (any_rst)
            nxt_misc = {1'b0, MISC_RST[6:0]}; // [R18] [R22]
        if (por_evt)
            nxt_misc[POR_BIT] = 1'b1; // [R4]
    end
    assign sel_change = (nxt_misc[RISE_BIT:FALL_BIT]
                         != misc_ff[RISE_BIT:FALL_BIT]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            misc_ff <= MISC_RST;
        else
            misc_ff <= nxt_misc;
    end

    // ------------------------------------------------------------
    // timer, serial, cpu state effects
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_cnt_ff <= TIMER_RST;
            prescale_ff <= 8'h00;
            timer_en_ff <= 4'h0;
        end else if (any_rst) begin
            timer_cnt_ff <= TIMER_RST; // [R1]
            prescale_ff <= 8'h00;
            timer_en_ff <= 4'h0; // [R5]
        end else begin
            if (wr && paddr == IRQ_TIMER_ADDR)
                timer_en_ff <= pwdata[27:24];
            prescale_ff <= prescale_ff + 8'h01;
            if (prescale_ff == 8'hFF)
                timer_cnt_ff <= timer_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_on_ff <= 1'b0;
            ser_en_ff <= 4'h0;
            tx_empty_ff <= 1'b1;
            tx_done_ff <= 1'b1;
        end else if (any_rst) begin
            ser_on_ff <= 1'b0; // [R6]
            ser_en_ff <= 4'h0;
            tx_empty_ff <= 1'b1;
            tx_done_ff <= 1'b1;
        end else if (wr && paddr == IRQ_SERIAL_ADDR) begin
            ser_on_ff <= pwdata[7];
            ser_en_ff <= pwdata[3:0];
            tx_empty_ff <= pwdata[6];
            tx_done_ff <= pwdata[5];
        end
    end

    // effect pulses out to the rest of the chip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fx_ff <= '0;
        end else begin
            fx_ff.timer_reset <= any_rst; // [R1]
            fx_ff.ddr_clear <= any_rst; // [R2]
            fx_ff.fetch_restart <= any_rst;
            fx_ff.serial_reset <= any_rst;
            fx_ff.clk_clear <= por_evt | cmd_stop; // [R7]
            fx_ff.adc_disable <= any_rst | cmd_stop; // [R8]
            fx_ff.eeprom_reset <= any_rst | cmd_stop;
            fx_ff.cop_count_reset <= any_rst | cmd_stop | cmd_wait; // [R9]
        end
    end

    // oscillator hold after power-on or stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            osc_cnt_ff <= 13'h0000;
        else if (por_evt || cmd_stop)
            osc_cnt_ff <= 13'(OSC_HOLD_CYC); // [R7]
        else if (osc_cnt_ff != 13'h0000)
            osc_cnt_ff <= osc_cnt_ff - 13'h0001;
    end
    assign osc_enable = (osc_cnt_ff == 13'h0000);

    // ------------------------------------------------------------
    // external pin sensing
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pin_sync_ff <= 3'b111;
        else
            pin_sync_ff <= {pin_sync_ff[1:0], irq_pin_n};
    end
    logic pin_n, pin_prev, fall_edge, rise_edge, edge_hit, level_mode;
    assign pin_n = pin_sync_ff[1];
    assign pin_prev = pin_sync_ff[2];
    assign fall_edge = pin_prev & ~pin_n;
    assign rise_edge = ~pin_prev & pin_n;
    assign level_mode = ~misc_ff[RISE_BIT] & ~misc_ff[FALL_BIT];
    always_comb begin
        case ({misc_ff[RISE_BIT], misc_ff[FALL_BIT]}) // [R16]
            2'b00: edge_hit = fall_edge;
            2'b01: edge_hit = fall_edge;
            2'b10: edge_hit = rise_edge;
            2'b11: edge_hit = fall_edge | rise_edge;
            default: edge_hit = 1'b0;
        endcase
    end
    logic take_ext;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ext_latch_ff <= 1'b0;
        else if (any_rst || (misc_wr && sel_change))
            ext_latch_ff <= 1'b0; // [R19]
        else if (edge_hit)
            ext_latch_ff <= 1'b1; // [R20]
        else if (take_ext)
            ext_latch_ff <= 1'b0; // [R21]
    end
    logic ext_req;
    // level request follows the pin live; a falling edge in level mode is also latched
    assign ext_req = misc_ff[EXT_EN_BIT]
                     & (ext_latch_ff | (level_mode & ~pin_n)); // [R24] [R15]

    // ------------------------------------------------------------
    // arbitration at instruction boundary
    // ------------------------------------------------------------
    logic [3:0] hw_req;
    assign hw_req = {serial_req, wrap_req, compare_req, capture_req};

    function automatic irq_src_e pick(input logic ext, input logic [3:0] r);
        if (ext)
            pick = IRQ_SRC_EXT;
        else if (r[0])
            pick = IRQ_SRC_CAPT;
        else if (r[1])
            pick = IRQ_SRC_CMP;
        else if (r[2])
            pick = IRQ_SRC_WRAP;
        else if (r[3])
            pick = IRQ_SRC_SER;
        else
            pick = IRQ_SRC_NONE;
    endfunction : pick
    function automatic logic [15:0] vec_of(input irq_src_e s);
        case (s) // [R13]
            IRQ_SRC_TRAP: vec_of = VEC_TRAP;
            IRQ_SRC_EXT: vec_of = VEC_EXT;
            IRQ_SRC_CAPT: vec_of = VEC_CAPT;
            IRQ_SRC_CMP: vec_of = VEC_CMP;
            IRQ_SRC_WRAP: vec_of = VEC_WRAP;
            IRQ_SRC_SER: vec_of = VEC_SER;
            default: vec_of = VEC_RESET;
        endcase
    endfunction : vec_of
    // hardware sources pending when trap was fetched go first
    irq_src_e hw_win, snap_win, win;
    assign hw_win = pick(ext_req, hw_req); // [R12]
    assign snap_win = pick(ext_req & pend_snap_ff[0],
                           hw_req & {pend_snap_ff[3:1], pend_snap_ff[0]});
    always_comb begin
        win = IRQ_SRC_NONE;
        if (cmd_bound) begin // [R11]
            if (trap_pend_ff) begin
                if (!mask_ff && snap_win != IRQ_SRC_NONE)
                    win = snap_win; // [R14]
                else
                    win = IRQ_SRC_TRAP;
            end else if (!mask_ff) begin
                win = hw_win;
            end
        end
    end
    assign take_ext = (win == IRQ_SRC_EXT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_pend_ff <= 1'b0;
            pend_snap_ff <= 4'h0;
        end else if (any_rst) begin
            trap_pend_ff <= 1'b0;
            pend_snap_ff <= 4'h0;
        end else if (cmd_trap) begin
            trap_pend_ff <= 1'b1;
            pend_snap_ff <= {hw_req[3:1], ext_req | hw_req[0]};
        end else if (win == IRQ_SRC_TRAP) begin
            trap_pend_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // mask bit, stack pointer, vector output
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= 1'b1;
            mask_stack_ff <= 1'b1;
            sp_ff <= SP_RST;
            vector_ff <= VEC_RESET;
            take_ff <= 1'b0;
            src_ff <= IRQ_SRC_NONE;
        end else if (any_rst) begin
            mask_ff <= 1'b1; // [R2]
            sp_ff <= SP_RST;
            vector_ff <= VEC_RESET;
            take_ff <= 1'b1;
            src_ff <= IRQ_SRC_NONE;
        end else begin
            take_ff <= 1'b0;
            if (win != IRQ_SRC_NONE) begin
                mask_stack_ff <= mask_ff; // [R10]
                mask_ff <= 1'b1;
                sp_ff <= sp_ff - 16'h0005;
                vector_ff <= vec_of(win);
                src_ff <= win;
                take_ff <= 1'b1;
            end else if (cmd_rti) begin
                mask_ff <= mask_stack_ff; // [R10]
                sp_ff <= sp_ff + 16'h0005;
            end else if (cmd_wait || cmd_stop) begin
                mask_ff <= 1'b0; // [R3]
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    mask_on_take_a: assert property (@(posedge pclk) // [R10]
        disable iff (!presetn) (win != IRQ_SRC_NONE && !any_rst) |=> mask_ff)
        else $error("mask not set after take");
    wait_clear_a: assert property (@(posedge pclk) // [R3]
        disable iff (!presetn) ((cmd_wait || cmd_stop) && !any_rst
        && win == IRQ_SRC_NONE && !cmd_rti) |=> !mask_ff)
        else $error("wait or stop left mask set");
    reset_vec_a: assert property (@(posedge pclk) // [R2]
        disable iff (!presetn) any_rst |=> vector_ff == VEC_RESET
        && sp_ff == SP_RST && mask_ff)
        else $error("reset did not restart cpu state");
    sel_locked_a: assert property (@(posedge pclk) // [R17]
        disable iff (!presetn) (!mask_ff && !any_rst)
        |=> $stable(misc_ff[RISE_BIT:EXT_EN_BIT]))
        else $error("select bits changed while unmasked");
    ext_vec_a: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
        (take_ext && !any_rst) |=> vector_ff == VEC_EXT
        && (!ext_latch_ff || $past(edge_hit)))
        else $error("external take wrong");
    por_flag_a: assert property (@(posedge pclk) // [R4]
        disable iff (!presetn) (cmd_ext && !por_evt) |=> !misc_ff[POR_BIT])
        else $error("external reset set power-up flag");
    timer_load_a: assert property (@(posedge pclk) // [R1]
        disable iff (!presetn) any_rst |=> timer_cnt_ff == TIMER_RST
        && prescale_ff == 8'h00 && timer_en_ff == 4'h0)
        else $error("timer not reset");
    osc_hold_a: assert property (@(posedge pclk) // [R7]
        disable iff (!presetn) (cmd_stop && !por_evt) |=> !osc_enable [*8])
        else $error("oscillator not held");
    no_take_masked_a: assert property (@(posedge pclk) // [R11]
        disable iff (!presetn) (mask_ff && !trap_pend_ff)
        |-> win == IRQ_SRC_NONE)
        else $error("masked interrupt taken");
    sel_clear_a: assert property (@(posedge pclk) // [R19]
        disable iff (!presetn) (misc_wr && sel_change && !any_rst)
        |=> !ext_latch_ff)
        else $error("pending external kept on option change");
endmodule : irq_ctrl

// [verification/irq_periph_model.sv]
// peripheral request model: timer and serial flags held until vectored
`timescale 1ns/100ps
module irq_periph_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] raise,
    input wire logic take_ff,
    input wire logic [15:0] vector_ff,
    output logic capture_req,
    output logic compare_req,
    output logic wrap_req,
    output logic serial_req
);
    import irq_pkg::*;
    logic [3:0] pend_ff;
    logic [3:0] clr;
    // the service routine clears only the flag it was vectored for
    always_comb begin
        clr = 4'h0;
        if (take_ff) begin
            case (vector_ff)
                VEC_CAPT: clr = 4'h8;
                VEC_CMP: clr = 4'h4;
                VEC_WRAP: clr = 4'h2;
                VEC_SER: clr = 4'h1;
                default: clr = 4'h0;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= 4'h0;
        end else begin
            pend_ff <= (pend_ff & ~clr) | raise;
        end
    end
    assign {capture_req, compare_req, wrap_req, serial_req} = pend_ff;
endmodule : irq_periph_model

// [verification/tb.sv]
// self-checking bench for the irq controller
`timescale 1ns/100ps
module tb;
    import irq_pkg::*;
    logic pclk, presetn, por_pulse, psel, penable, pwrite, irq_pin_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic pready, pslverr, take_ff, mask_ff, osc_enable;
    logic capture_req, compare_req, wrap_req, serial_req;
    logic [15:0] vector_ff;
    logic [3:0] raise;
    logic [63:0] note;
    irq_fx_s fx_ff;
    int err_count, check_count, low_n, i;
    logic [63:0] rd_q[$];
    logic [15:0] tk_q[$];
    logic [7:0] fx_q[$];
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    irq_ctrl dut (.pclk(pclk), .presetn(presetn), .por_pulse(por_pulse),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_pin_n(irq_pin_n),
        .capture_req(capture_req), .compare_req(compare_req),
        .wrap_req(wrap_req), .serial_req(serial_req), .fx_ff(fx_ff),
        .osc_enable(osc_enable), .vector_ff(vector_ff),
        .take_ff(take_ff), .mask_ff(mask_ff));
    irq_periph_model peri (.pclk(pclk), .presetn(presetn), .raise(raise),
        .take_ff(take_ff), .vector_ff(vector_ff),
        .capture_req(capture_req), .compare_req(compare_req),
        .wrap_req(wrap_req), .serial_req(serial_req));
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs
    task close_out;
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk
    task miss(input string nm);
        err_count++;
        $display("unexpected %s: expected none, seen one", nm);
    endtask : miss
    // one transfer; the request holds until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            miss("bus hang");
            close_out();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd_q.push_back({m, e});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task cmd(input int b);
        wr(IRQ_CMD_ADDR, 32'h1 << b);
    endtask : cmd
    task ext_rst;
        fx_q.push_back(8'hEF);
        tk_q.push_back(VEC_RESET);
        cmd(CMD_EXTRST);
    endtask : ext_rst
    task wait_cmd;
        fx_q.push_back(8'h02);
        cmd(CMD_WAIT);
    endtask : wait_cmd
    task pin(input logic v);
        irq_pin_n <= v;
        repeat (4) @(posedge pclk);
    endtask : pin
    task osc_hold;
        int k;
        k = 0;
        while (osc_enable !== 1'b0 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        while (osc_enable === 1'b0 && k < 5000) begin
            @(posedge pclk);
            k++;
        end
        chk("osc hold", OSC_HOLD_CYC, low_n);
        low_n = 0;
    endtask : osc_hold
    // ------------------------------------------------
    // monitor: each result takes the oldest note
    // ------------------------------------------------
    always @(posedge pclk) begin
        if (osc_enable === 1'b0) low_n = low_n + 1;
        if (presetn === 1'b1 && psel && penable && pready && !pwrite) begin
            if (rd_q.size() == 0) miss("read");
            else begin
                note = rd_q.pop_front();
                chk("prdata", note[31:0], prdata & note[63:32]);
            end
        end
        if (presetn === 1'b1 && psel && penable && pready)
            chk("pslverr", {31'h0, !(paddr inside {IRQ_MISC_ADDR,
                IRQ_CPU_ADDR, IRQ_TIMER_ADDR, IRQ_SERIAL_ADDR,
                IRQ_CMD_ADDR, IRQ_VEC_ADDR})}, {31'h0, pslverr});
        if (presetn === 1'b1 && take_ff === 1'b1) begin
            if (tk_q.size() == 0) miss("take");
            else chk("vector", {16'h0, tk_q.pop_front()}, {16'h0, vector_ff});
        end
        if (presetn === 1'b1 && fx_ff !== 8'h00) begin
            if (fx_q.size() == 0) miss("effect");
            else chk("effects", {24'h0, fx_q.pop_front()}, {24'h0, fx_ff});
        end
    end
    // ------------------------------------------------
    // sequence
    // ------------------------------------------------
    initial begin
        {presetn, por_pulse, psel, penable, pwrite} = 5'h00;
        {paddr, pwdata, raise, irq_pin_n} = 45'h1;
        {err_count, check_count, low_n} = 0;
        seed = 32'd78;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(IRQ_MISC_ADDR, 32'hFF, 32'h10);
        rd(IRQ_CPU_ADDR, 32'h1FFFF, 32'h100FF);
        rd(IRQ_TIMER_ADDR, 32'h0F00FFFF, 32'h0000FFFC);
        rd(IRQ_SERIAL_ADDR, 32'hFF, 32'h60);
        rd(IRQ_VEC_ADDR, 32'hFFFF, 32'h1FFE);
        rd(8'h04, 32'h0, 32'h0);
        $display("test reset values done");
        fx_q.push_back(8'hFF);
        tk_q.push_back(VEC_RESET);
        por_pulse <= 1'b1;
        @(posedge pclk);
        por_pulse <= 1'b0;
        osc_hold();
        rd(IRQ_MISC_ADDR, 32'hFF, 32'h90);
        wr(IRQ_MISC_ADDR, 32'h10);
        wr(IRQ_MISC_ADDR, 32'h90);
        rd(IRQ_MISC_ADDR, 32'hFF, 32'h10);
        $display("test power-on done");
        seed = xs(seed);
        wr(IRQ_TIMER_ADDR, {4'h0, seed[3:0], 24'h0});
        wr(IRQ_SERIAL_ADDR, {24'h0, seed[7:4] | 4'h8, seed[11:8]});
        rd(IRQ_TIMER_ADDR, 32'h0F000000, {4'h0, seed[3:0], 24'h0});
        rd(IRQ_SERIAL_ADDR, 32'h0F, {28'h0, seed[11:8]});
        ext_rst();
        rd(IRQ_TIMER_ADDR, 32'h0F000000, 32'h0);
        rd(IRQ_SERIAL_ADDR, 32'hFF, 32'h60);
        rd(IRQ_CPU_ADDR, 32'h10000, 32'h10000);
        rd(IRQ_MISC_ADDR, 32'hFF, 32'h10);
        $display("test external reset done");
        wait_cmd();
        rd(IRQ_CPU_ADDR, 32'h10000, 32'h0);
        wr(IRQ_MISC_ADDR, 32'h72);
        rd(IRQ_MISC_ADDR, 32'hFF, 32'h12);
        fx_q.push_back(8'h1E);
        cmd(CMD_STOP);
        osc_hold();
        rd(IRQ_MISC_ADDR, 32'hFF, 32'h10);
        $display("test wait and stop done");
        raise <= 4'hF;
        @(posedge pclk);
        raise <= 4'h0;
        for (i = 0; i < 4; i++) begin
            tk_q.push_back(VEC_CAPT - 16'(2 * i));
            cmd(CMD_BOUND);
            rd(IRQ_CPU_ADDR, 32'h10000, 32'h10000);
            cmd(CMD_BOUND);
            cmd(CMD_RTI);
            rd(IRQ_CPU_ADDR, 32'h10000, 32'h0);
        end
        $display("test priority done");
        ext_rst();
        wr(IRQ_MISC_ADDR, 32'h20);
        pin(1'b0);
        pin(1'b1);
        wr(IRQ_MISC_ADDR, 32'h30);
        wait_cmd();
        tk_q.push_back(VEC_EXT);
        cmd(CMD_BOUND);
        cmd(CMD_RTI);
        cmd(CMD_BOUND);
        ext_rst();
        wr(IRQ_MISC_ADDR, 32'h30);
        pin(1'b0);
        pin(1'b1);
        wr(IRQ_MISC_ADDR, 32'h50);
        rd(IRQ_MISC_ADDR, 32'hFF, 32'h50);
        wait_cmd();
        cmd(CMD_BOUND);
        pin(1'b0);
        tk_q.push_back(VEC_EXT);
        pin(1'b1);
        cmd(CMD_BOUND);
        ext_rst();
        pin(1'b0);
        wait_cmd();
        tk_q.push_back(VEC_EXT);
        tk_q.push_back(VEC_EXT);
        cmd(CMD_BOUND);
        cmd(CMD_RTI);
        cmd(CMD_BOUND);
        pin(1'b1);
        $display("test external pin done");
        wait_cmd();
        raise <= 4'h8;
        @(posedge pclk);
        raise <= 4'h0;
        cmd(CMD_TRAP);
        tk_q.push_back(VEC_CAPT);
        tk_q.push_back(VEC_TRAP);
        cmd(CMD_BOUND);
        cmd(CMD_RTI);
        cmd(CMD_BOUND);
        repeat (4) @(posedge pclk);
        chk("notes left", 32'h0, rd_q.size() + tk_q.size() + fx_q.size());
        $display("test trap done");
        close_out();
    end
endmodule : tb
